// [logic/efad_decoder.sv]
`timescale 1ns/1ps
// Summary of operation
// - base select 000 first, 001 second
// - direction one writes pair data
// - direction zero reads, data discarded
// - function 000 serial, 001 parallel
// - low byte is offset from base
// - top bit zero ends the zone
// - access looks like host byte access
module efad_decoder import efad_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  output logic word_ready,
  output logic acc_strobe,
  output logic acc_write,
  output logic acc_serial,
  output logic acc_parallel,
  output logic acc_base_second,
  output logic [7:0] acc_offset,
  output logic [7:0] acc_wdata,
  output logic zone_done,
  output logic skipped
);

  // the loader keeps the control word and the data byte of a pair, since the access can only
  // be made once the data word has arrived
  efad_state_t state; // loader position
  logic [15:0] first_word; // held control word of the pair
  logic [7:0] data_word; // held data byte of the second word
  logic take; // word accepted this cycle
  logic issue_now; // pair complete, access due this cycle
  logic pair_ok; // both codes of the held pair are defined
  logic base_ok; // base code is defined
  logic func_ok; // function code is defined
  logic [2:0] base_sel; // base field of held word
  logic [2:0] func_sel; // function field of held word

  // a word is taken only while ready is shown, so no word is lost
  // and none is counted twice
  assign take = word_valid && word_ready;
  // field slices of the held control word
  assign base_sel = first_word[EFAD_BASE_HI:EFAD_BASE_LO];
  assign func_sel = first_word[EFAD_FUNC_HI:EFAD_FUNC_LO];
  // defined base codes
  assign base_ok = (base_sel == EFAD_BASE_FIRST) || (base_sel == EFAD_BASE_SECOND);
  // defined function codes
  assign func_ok = (func_sel == EFAD_FUNC_SERIAL) || (func_sel == EFAD_FUNC_PARALLEL);
  // a reserved code in either field turns the pair into a skip
  assign pair_ok = base_ok && func_ok;
  // the issue state lasts exactly one cycle
  assign issue_now = (state == EFAD_ST_ISSUE);

  // sequencing of first word, second word and the access
  // the loader waits in the done state after reset, so nothing is
  // fetched before the download reaches the function access zone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= EFAD_ST_DONE;
      first_word <= EFAD_WORD_RST;
      data_word <= EFAD_BYTE_RST;
    end else begin
      case (state)
        EFAD_ST_FIRST: begin
          // first word: top bit zero means a lone terminating word
          if (take) begin
            first_word <= word_data;
            if (word_data[EFAD_MORE_BIT]) begin
              state <= EFAD_ST_SECOND;
            end else begin
              state <= EFAD_ST_DONE;
            end
          end
        end
        EFAD_ST_SECOND: begin
          // second word carries the write data
          if (take) begin
            // only the low byte carries data, the top byte is ignored
            data_word <= word_data[7:0];
            state <= EFAD_ST_ISSUE;
          end
        end
        EFAD_ST_ISSUE: begin
          // access issued this cycle, then the next pair
          // a reserved pair passes through here too, only without an access
          state <= EFAD_ST_FIRST;
        end
        EFAD_ST_DONE: begin
          // idle until the download reaches this zone again
          if (start) begin
            state <= EFAD_ST_FIRST;
          end
        end
        default: begin
          // an illegal state code falls back to idle
          state <= EFAD_ST_DONE;
        end
      endcase
    end
  end

  // ready while a word is wanted, registered for the next cycle
  // it drops for the cycle after every taken word, which gives the
  // state register time to move before the next word is accepted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_ready <= 1'b0;
    end else begin
      case (state)
        EFAD_ST_FIRST: begin
          // a taken control word or terminator closes the window
          word_ready <= !take;
        end
        EFAD_ST_SECOND: begin
          // the data word is awaited, then the access slot follows
          word_ready <= !take;
        end
        EFAD_ST_ISSUE: begin
          // access goes out now, the next control word may come
          word_ready <= 1'b1;
        end
        EFAD_ST_DONE: begin
          // stays low after the terminator until the next start
          word_ready <= start;
        end
        default: begin
          word_ready <= 1'b0;
        end
      endcase
    end
  end

  // the access fields below load together, only for a good pair, and
  // hold until the next one; a skipped pair leaves them untouched

  // access strobe: a single cycle, only for a pair with defined codes
  // the default low keeps it from ever stretching into a second access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_strobe <= 1'b0;
    end else begin
      acc_strobe <= issue_now && pair_ok;
    end
  end

  // direction of the access: one writes the data byte, zero reads
  // a read answer is never brought back, the target only sees the cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_write <= 1'b0;
    end else if (issue_now && pair_ok) begin
      acc_write <= first_word[EFAD_DIR_BIT];
    end
  end

  // target function, one hot between serial and parallel
  // held after the strobe so a slow target can still look at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_serial <= 1'b0;
      acc_parallel <= 1'b0;
    end else if (issue_now && pair_ok) begin
      acc_serial <= (func_sel == EFAD_FUNC_SERIAL);
      acc_parallel <= (func_sel == EFAD_FUNC_PARALLEL);
    end
  end

  // which base register of the function the offset is taken from
  // zero picks the first base register, one the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_base_second <= 1'b0;
    end else if (issue_now && pair_ok) begin
      acc_base_second <= (base_sel == EFAD_BASE_SECOND);
    end
  end

  // byte offset from the selected base, as a host byte cycle carries it
  // the target adds it to its own base, nothing is added here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_offset <= EFAD_BYTE_RST;
    end else if (issue_now && pair_ok) begin
      acc_offset <= first_word[EFAD_OFS_HI:0];
    end
  end

  // write data from the second word; it is loaded on reads too,
  // where the target ignores it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_wdata <= EFAD_BYTE_RST;
    end else if (issue_now && pair_ok) begin
      acc_wdata <= data_word;
    end
  end

  // skip pulse: the pair was consumed but no access was made
  // the loader then goes on with the next pair as usual
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skipped <= 1'b0;
    end else begin
      skipped <= issue_now && !pair_ok;
    end
  end

  // zone finished pulse, one cycle after the terminator is taken
  // the terminator is a lone word, so no data word is waited for
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_done <= 1'b0;
    end else begin
      zone_done <= (state == EFAD_ST_FIRST) && take && !word_data[EFAD_MORE_BIT];
    end
  end

endmodule

// [logic/efad_pkg.sv]
package efad_pkg;
  // first word field positions
  localparam int unsigned EFAD_MORE_BIT = 15;      // pair follows when set
  localparam int unsigned EFAD_BASE_HI = 14;       // base register select, top bit
  localparam int unsigned EFAD_BASE_LO = 12;       // base register select, low bit
  localparam int unsigned EFAD_DIR_BIT = 11;       // 1 write, 0 read
  localparam int unsigned EFAD_FUNC_HI = 10;       // function select, top bit
  localparam int unsigned EFAD_FUNC_LO = 8;        // function select, low bit
  localparam int unsigned EFAD_OFS_HI = 7;         // offset, top bit
  // field codes
  localparam logic [2:0] EFAD_BASE_FIRST = 3'h0;   // first i/o base register
  localparam logic [2:0] EFAD_BASE_SECOND = 3'h1;  // second i/o base register
  localparam logic [2:0] EFAD_FUNC_SERIAL = 3'h0;  // serial port function
  localparam logic [2:0] EFAD_FUNC_PARALLEL = 3'h1; // parallel port function
  // reset values
  localparam logic [15:0] EFAD_WORD_RST = 16'h0000; // held first word
  localparam logic [7:0] EFAD_BYTE_RST = 8'h00;     // byte outputs

  // loader states
  typedef enum logic [1:0] {
    EFAD_ST_FIRST,
    EFAD_ST_SECOND,
    EFAD_ST_ISSUE,
    EFAD_ST_DONE
  } efad_state_t;
endpackage

// [sim/efad_props.sv]
`timescale 1ns/1ps
module efad_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic acc_strobe,
  input wire logic acc_write,
  input wire logic acc_serial,
  input wire logic acc_parallel,
  input wire logic acc_base_second,
  input wire logic zone_done,
  input wire logic skipped,
  input wire logic [15:0] word_data,
  input wire logic [7:0] acc_offset,
  input wire logic [7:0] acc_wdata
);
  logic sec; // next word taken is a data word
  logic [15:0] w1; // held control word
  wire tk = word_valid && word_ready;
  wire ok = w1[14:13] == 2'h0 && w1[10:9] == 2'h0;
  // track control or data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sec <= 1'b0;
    else if (tk) sec <= !sec && word_data[15];
  end
  always_ff @(posedge clk) if (tk && !sec) w1 <= word_data;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  term_done_a: assert property (tk && !sec && !word_data[15] |=> zone_done)
    else $error("no zone end");
  issue_ofs_a: assert property (tk && sec && ok |-> ##2
    acc_strobe && acc_offset == w1[7:0])
    else $error("bad offset");
  write_data_a: assert property (tk && sec && ok |-> ##2
    acc_write == w1[11] && acc_wdata == $past(word_data[7:0], 2))
    else $error("bad direction or data");
  skip_pair_a: assert property (tk && sec && !ok |-> ##2 skipped && !acc_strobe)
    else $error("reserved pair not skipped");
  target_sel_a: assert property (acc_strobe |->
    acc_base_second == w1[12] && acc_parallel == w1[8])
    else $error("bad target");
  one_func_a: assert property (acc_strobe |-> acc_serial ^ acc_parallel)
    else $error("bad function");
  strobe_pulse_a: assert property (acc_strobe |=> !acc_strobe)
    else $error("long strobe");
  no_early_a: assert property (tk && !sec |=> !acc_strobe && !skipped)
    else $error("early access");
  hold_off_a: assert property (zone_done |-> !word_ready)
    else $error("ready after zone end");
  idle_hold_a: assert property (zone_done && !start |=> !word_ready)
    else $error("ready without start");
  cover property (acc_strobe && acc_write);
  cover property (skipped);
  cover property (zone_done);
endmodule
bind efad_decoder efad_props chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .start(start),
  .word_valid(word_valid),
  .word_ready(word_ready),
  .acc_strobe(acc_strobe),
  .acc_write(acc_write),
  .acc_serial(acc_serial),
  .acc_parallel(acc_parallel),
  .acc_base_second(acc_base_second),
  .zone_done(zone_done),
  .skipped(skipped),
  .word_data(word_data),
  .acc_offset(acc_offset),
  .acc_wdata(acc_wdata)
);

// [sim/efad_eeprom.sv]
`timescale 1ns/1ps
module efad_eeprom (
  input wire logic clk,
  input wire logic start,
  input wire logic word_ready,
  output logic word_valid,
  output logic [15:0] word_data);
  logic [15:0] img [0:31]; // download image, filled by the bench
  logic [15:0] last_w = 16'h0000; // last word handed over
  int idx = 32; // next word, parked past the end
  assign word_valid = idx < 32;
  // image order, zero terminator ends the zone
  // with nothing to offer the lines show the inverse of the last word
  assign word_data = word_valid ? img[idx] : ~last_w;
  always @(posedge clk) begin
    if (start) idx <= 0;
    else if (word_valid && word_ready) begin
      idx <= idx + 1;
      last_w <= img[idx];
    end
  end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0;
  logic word_valid, word_ready, acc_strobe, acc_write, acc_serial, acc_parallel;
  logic acc_base_second, zone_done, skipped;
  logic [15:0] word_data;
  logic [7:0] acc_offset, acc_wdata;
  logic [19:0] exp [0:7]; // expected access fields in order
  logic [19:0] acc_seen; // access fields as one word
  assign acc_seen = {acc_write, acc_base_second, acc_parallel, acc_serial,
    acc_offset, acc_wdata};
  int num_errors = 0, checks = 0, ns, nk, nd, cyc = 0;
  always #50 clk = ~clk;
  efad_decoder dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .start(start),
    .word_valid(word_valid),
    .word_data(word_data),
    .word_ready(word_ready),
    .acc_strobe(acc_strobe),
    .acc_write(acc_write),
    .acc_serial(acc_serial),
    .acc_parallel(acc_parallel),
    .acc_base_second(acc_base_second),
    .acc_offset(acc_offset),
    .acc_wdata(acc_wdata),
    .zone_done(zone_done),
    .skipped(skipped)
  );
  efad_eeprom ee_u (
    .clk(clk),
    .start(start),
    .word_ready(word_ready),
    .word_valid(word_valid),
    .word_data(word_data)
  );
  task automatic chk(string what, logic [19:0] seen, logic [19:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // compare each access, count skips and zone ends, cut a hang
  always @(negedge clk) begin
    if (acc_strobe) chk("access", acc_seen, exp[ns++]);
    nk += skipped;
    nd += zone_done;
    if (++cyc == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  // start a zone and wait for its end
  task automatic zone();
    {ns, nk, nd} = 0;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    for (int i = 0; i < 200 && nd == 0; i++) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  // every base, direction and function, offsets 00 to ff
  task automatic t_codes();
    logic [7:0] o, d;
    for (int i = 0; i < 8; i++) begin
      o = 8'(i * 'h49);
      d = 8'(i * 'h24);
      ee_u.img[2 * i] = {1'b1, 2'h0, i[1], i[2], 2'h0, i[0], o};
      ee_u.img[2 * i + 1] = {8'ha5, d};
      exp[i] = {i[2], i[1], i[0], !i[0], o, d};
    end
    ee_u.img[16] = 16'h0000;
    ee_u.img[17] = 16'h880f;
    zone();
    chk("accesses", 20'(ns), 20'h8);
    chk("zone ends", 20'(nd), 20'h1);
    chk("words taken", 20'(ee_u.idx), 20'h11);
    $display("t_codes finished");
  endtask
  // reserved base and function codes are skipped
  task automatic t_reserved();
    ee_u.img[0:6] = '{16'hc012, 16'h0011, 16'h8c00, 16'h0022, 16'h8901, 16'h0033, 16'h0000};
    exp[0] = {4'ha, 8'h01, 8'h33};
    zone();
    chk("accesses", 20'(ns), 20'h1);
    chk("skips", 20'(nk), 20'h2);
    chk("zone ends", 20'(nd), 20'h1);
    $display("t_reserved finished");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_codes();
    t_reserved();
    end_of_test();
  end
endmodule
